// file: rtl/otw_slave.sv
// Two-wire command slave for the oscillator: address, command and register access
module otw_slave
    import otw_pkg::*;
#(
    parameter int TEMP_BITS = TEMP_RESULT_BITS
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output logic                   scl_out,
    output logic                   scl_oe,
    input  wire logic              address_strap_pin,
    input  wire logic [TEMP_BITS-1:0] temp_result,
    input  wire logic              temp_valid,
    output otw_pkg::otw_regs_t     regs
);
    // Refuse parameter values the datapath cannot serve
    if (TEMP_BITS != TEMP_RESULT_BITS) begin : g_bad_temp_bits
        $error("otw_slave: only a 10-bit temperature result is served");
    end
    if (SCL_HIGH_CYC < 8) begin : g_slow_clock
        $error("otw_slave: system clock too slow for fast-mode sampling");
    end

    logic        scl_level;
    logic        sda_level;
    otw_bus_ev_t ev;

    // Lines cross into ref_clk through three stages each
    otw_line_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .line_in    (scl_in),
        .line_level (scl_level)
    );
    otw_line_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .line_in    (sda_in),
        .line_level (sda_level)
    );
    otw_edge_detect u_edges (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .scl_level (scl_level),
        .sda_level (sda_level),
        .bus_ev    (ev)
    );

    // Clock line is never driven by the slave
    assign scl_out = 1'b1;
    assign scl_oe  = 1'b0;

    // Strap is a pin like the bus wires, so it gets the same filter
    logic                  strap_level;
    logic [TEMP_WIDTH-1:0] temp_q;
    logic [TEMP_WIDTH-1:0] temp_d;

    otw_line_sync #(.RESET_LEVEL(1'b0)) u_strap_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .line_in    (address_strap_pin),
        .line_level (strap_level)
    );

    // Latest completed conversion, left-aligned with zero tail
    always_comb begin
        temp_d  = temp_q;
        if (temp_valid) begin
            temp_d = {temp_result, {TEMP_FRAC_LSB{1'b0}}};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            temp_q  <= '0;
        end else begin
            temp_q  <= temp_d;
        end
    end

    otw_state_t state_q;
    otw_state_t state_d;
    otw_state_t after_ack_q;
    otw_state_t after_ack_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic       cmd_ok_q;
    logic       cmd_ok_d;
    logic       read_lsb_q;
    logic       read_lsb_d;
    logic       drive_low_q;
    logic       drive_low_d;
    logic       ack_is_ours_q;
    logic       ack_is_ours_d;
    logic [7:0] temp_lsb_q;
    logic [7:0] temp_lsb_d;
    otw_regs_t  regs_q;
    otw_regs_t  regs_d;
    logic [7:0] rd_byte;

    // Byte to send for the selected command; no pointer advance
    always_comb begin
        case (cmd_q)
            CMD_DIVIDER:     rd_byte = regs_q.divider;
            CMD_CONTROL:     rd_byte = regs_q.control;
            CMD_TRIM:        rd_byte = regs_q.trim;
            CMD_TEMPERATURE: rd_byte = read_lsb_q ? temp_lsb_q : temp_q[15:8];
            default:         rd_byte = 8'hFF;
        endcase
    end

    // Protocol engine: samples on clock rise, shifts on clock fall
    always_comb begin
        state_d       = state_q;
        after_ack_d   = after_ack_q;
        shift_d       = shift_q;
        bit_cnt_d     = bit_cnt_q;
        cmd_d         = cmd_q;
        cmd_ok_d      = cmd_ok_q;
        read_lsb_d    = read_lsb_q;
        drive_low_d   = drive_low_q;
        ack_is_ours_d = ack_is_ours_q;
        temp_lsb_d    = temp_lsb_q;
        regs_d        = regs_q;
        if (ev.start) begin
            // START or repeated START restarts address phase
            state_d     = ST_ADDR;
            bit_cnt_d   = 4'h0;
            drive_low_d = 1'b0;
        end else if (ev.stop) begin
            // STOP returns to idle
            state_d     = ST_IDLE;
            drive_low_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE, ST_WAIT: begin
                    drive_low_d = 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    // Receive eight bits MSB first
                    if (ev.scl_rise) begin
                        shift_d   = {shift_q[6:0], ev.sda};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (ev.scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d   = 4'h0;
                        state_d     = ST_ACK;
                        drive_low_d = 1'b1;
                        ack_is_ours_d = 1'b1;
                        if (state_q == ST_ADDR) begin
                            // Address plus direction, bit 0 from strap
                            if (shift_q[7:1] == {ADDR_UPPER, strap_level}) begin
                                if (shift_q[0]) begin
                                    after_ack_d = ST_RDATA;
                                    read_lsb_d  = 1'b0;
                                end else begin
                                    after_ack_d = ST_CMD;
                                end
                            end else begin
                                // Foreign address: no acknowledge
                                drive_low_d = 1'b0;
                                state_d     = ST_WAIT;
                            end
                        end else if (state_q == ST_CMD) begin
                            // Fresh command; unknown codes are taken but inert
                            cmd_d       = shift_q;
                            cmd_ok_d    = (shift_q == CMD_DIVIDER) || (shift_q == CMD_CONTROL)
                                       || (shift_q == CMD_TEMPERATURE) || (shift_q == CMD_TRIM);
                            after_ack_d = ST_WDATA;
                        end else begin
                            // Every data byte writes the commanded divider, control or trim register again
                            if (cmd_ok_q) begin
                                case (cmd_q)
                                    CMD_DIVIDER: regs_d.divider = shift_q;
                                    CMD_CONTROL: regs_d.control = shift_q;
                                    CMD_TRIM:    regs_d.trim    = shift_q;
                                    default:     regs_d         = regs_q;
                                endcase
                            end
                            // Later bytes still acknowledged
                            after_ack_d = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    // Hold low across the whole ninth clock high
                    if (ev.scl_fall) begin
                        state_d     = after_ack_q;
                        bit_cnt_d   = 4'h0;
                        drive_low_d = 1'b0;
                        if (after_ack_q == ST_RDATA) begin
                            shift_d     = rd_byte;
                            drive_low_d = ~rd_byte[7];
                            // Freeze low byte with high byte: no torn word
                            temp_lsb_d  = temp_q[7:0];
                        end
                    end
                end
                ST_RDATA: begin
                    // Shift out MSB first on clock falls
                    if (ev.scl_fall) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7) begin
                            state_d     = ST_MACK;
                            drive_low_d = 1'b0;
                        end else begin
                            shift_d     = {shift_q[6:0], 1'b1};
                            drive_low_d = ~shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    // Master answer: ACK continues, NACK releases line
                    if (ev.scl_rise) begin
                        ack_is_ours_d = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        bit_cnt_d = 4'h0;
                        if (ack_is_ours_q) begin
                            // Second temperature byte if asked for
                            read_lsb_d  = 1'b1;
                            state_d     = ST_RDATA;
                            shift_d     = (cmd_q == CMD_TEMPERATURE) ? temp_lsb_q : rd_byte;
                            drive_low_d = (cmd_q == CMD_TEMPERATURE) ? ~temp_lsb_q[7] : ~rd_byte[7];
                        end else begin
                            state_d     = ST_WAIT;
                            drive_low_d = 1'b0;
                        end
                    end
                end
                default: begin
                    state_d     = ST_IDLE;
                    drive_low_d = 1'b0;
                end
            endcase
        end
    end

    // Protocol state registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q       <= ST_IDLE;
            after_ack_q   <= ST_IDLE;
            shift_q       <= 8'h00;
            bit_cnt_q     <= 4'h0;
            cmd_q         <= 8'h00;
            cmd_ok_q      <= 1'b0;
            read_lsb_q    <= 1'b0;
            drive_low_q   <= 1'b0;
            ack_is_ours_q <= 1'b0;
            temp_lsb_q    <= 8'h00;
            regs_q        <= '{divider: DIVIDER_RESET, control: CONTROL_RESET, trim: TRIM_RESET};
        end else begin
            state_q       <= state_d;
            after_ack_q   <= after_ack_d;
            shift_q       <= shift_d;
            bit_cnt_q     <= bit_cnt_d;
            cmd_q         <= cmd_d;
            cmd_ok_q      <= cmd_ok_d;
            read_lsb_q    <= read_lsb_d;
            drive_low_q   <= drive_low_d;
            ack_is_ours_q <= ack_is_ours_d;
            temp_lsb_q    <= temp_lsb_d;
            regs_q        <= regs_d;
        end
    end

    // Open drain: only ever pull low; sampling margin covers 400 kHz
    assign sda_out = 1'b0;
    assign sda_oe  = drive_low_q;
    // Fields leave undecoded; the oscillator core gives them meaning
    assign regs    = regs_q;
endmodule : otw_slave

// file: rtl/otw_pkg.sv
// Package: constants, commands and carriers for the oscillator two-wire command slave
package otw_pkg;

    // Command codes that select a register
    localparam logic [7:0] CMD_DIVIDER     = 8'h5D;
    localparam logic [7:0] CMD_CONTROL     = 8'h60;
    localparam logic [7:0] CMD_TEMPERATURE = 8'h64;
    localparam logic [7:0] CMD_TRIM        = 8'h66;

    // Reset values of the writable registers
    localparam logic [7:0] DIVIDER_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] TRIM_RESET      = 8'h00;

    // Slave address upper six bits; arbitrary value, the strap supplies bit 0
    localparam logic [5:0] ADDR_UPPER      = 6'h24;

    // Field layout of the temperature word
    localparam int TEMP_WIDTH      = 16;
    localparam int TEMP_RESULT_BITS = 10;
    localparam int TEMP_FRAC_LSB   = 6;

    // Bit rate limits served by the sampler
    localparam int CLK_HZ          = 125_000_000;
    localparam int FAST_MODE_HZ    = 400_000;
    localparam int STD_MODE_HZ     = 100_000;
    // Least clock-high time, 600 ns in fast mode, in system cycles (round down)
    localparam int SCL_HIGH_MIN_NS = 600;
    localparam int SCL_HIGH_CYC    = (SCL_HIGH_MIN_NS * (CLK_HZ / 1_000_000)) / 1000;

    // Register set as seen by the oscillator core
    typedef struct packed {
        logic [7:0] divider;
        logic [7:0] control;
        logic [7:0] trim;
    } otw_regs_t;

    // Bus events from the bus condition detector
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } otw_bus_ev_t;

    // Protocol states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_ACK   = 3'b101,
        ST_MACK  = 3'b110,
        ST_WAIT  = 3'b111
    } otw_state_t;

endpackage : otw_pkg

// file: rtl/otw_line_sync.sv
// Three-stage line sampler for one bus wire
module otw_line_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic line_in,
    output logic      line_level
);
    logic [2:0] shift_q;
    logic [2:0] shift_d;
    logic       level_q;
    logic       level_d;

    // Only the second and third stages are compared; the first is metastable
    always_comb begin
        shift_d = {shift_q[1:0], line_in};
        level_d = (shift_q[1] == shift_q[2]) ? shift_q[2] : level_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            shift_q <= {3{RESET_LEVEL}};
            level_q <= RESET_LEVEL;
        end else begin
            shift_q <= shift_d;
            level_q <= level_d;
        end
    end

    assign line_level = level_q;
endmodule : otw_line_sync

// file: rtl/otw_edge_detect.sv
// Bus condition detector: START, STOP and clock edges from filtered levels
module otw_edge_detect
    import otw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        scl_level,
    input  wire logic        sda_level,
    output otw_pkg::otw_bus_ev_t bus_ev
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_level;
            sda_q <= sda_level;
        end
    end

    // Data moving while clock is high is a bus condition
    always_comb begin
        bus_ev.start    = scl_q & scl_level & sda_q & ~sda_level;
        bus_ev.stop     = scl_q & scl_level & ~sda_q & sda_level;
        bus_ev.scl_rise = ~scl_q & scl_level;
        bus_ev.scl_fall = scl_q & ~scl_level;
        bus_ev.sda      = sda_level;
    end
endmodule : otw_edge_detect

// file: test/otw_chk.sv
// Checker: port-level protocol properties of the two-wire command slave
module otw_chk
    import otw_pkg::*;
#(
    parameter int TEMP_BITS = TEMP_RESULT_BITS
) (
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    input wire logic                 scl_in,
    input wire logic                 sda_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire logic                 scl_out,
    input wire logic                 scl_oe,
    input wire logic                 address_strap_pin,
    input wire logic [TEMP_BITS-1:0] temp_result,
    input wire logic                 temp_valid,
    input wire otw_pkg::otw_regs_t   regs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic       scl_q, sda_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Raw clock rises since the last START, saturating so idle time cannot wrap
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        if (scl_in && sda_q && !sda_in) begin
            bit_cnt_d = 4'h0;
        end else if (scl_in && !scl_q && bit_cnt_q != 4'hF) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
        end
    end

    // Helper registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bit_cnt_q <= 4'hF;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            scl_q     <= scl_in;
            sda_q     <= sda_in;
        end
    end

    a_scl_released: assert property (!scl_oe)
        else $error("slave drives the clock line");
    a_sda_pull_only: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("data pull released too early");
    a_stop_idle: assert property ($rose(sda_in) && scl_in |=> !sda_oe [*8])
        else $error("slave active after stop");
    a_start_quiet: assert property ($fell(sda_in) && scl_in |=> !sda_oe [*8])
        else $error("slave drives during address after start");
    a_addr_ack_slot: assert property ($rose(sda_oe) && bit_cnt_q < 9 |-> bit_cnt_q == 8)
        else $error("address acknowledge in wrong bit slot");
    a_regs_quiet_high: assert property (!$stable(regs) |-> !scl_in)
        else $error("register changed while clock high");
endmodule : otw_chk

bind otw_slave otw_chk #(.TEMP_BITS(TEMP_BITS)) i_otw_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .address_strap_pin(address_strap_pin), .temp_result(temp_result),
    .temp_valid(temp_valid), .regs(regs));

// file: test/otw_master.sv
// Partner model: two-wire bus master, one link period is four quarters of 40 ns
module otw_master (
    input wire logic ref_clk,
    input wire logic sda_line,
    output logic     scl_drv,
    output logic     sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QTR = 5;

    // Released lines float high through the pull-ups
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic q();
        repeat (QTR) @(negedge ref_clk);
    endtask : q

    // Also serves as repeated start; only the master makes clock pulses
    task automatic start();
        sda_drv = 1'b1;
        q();
        scl_drv = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl_drv = 1'b0;
        q();
    endtask : start

    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl_drv = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
        q();
    endtask : stop

    // Data set mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        q();
        scl_drv = 1'b1;
        q();
        r = sda_line;
        q();
        scl_drv = 1'b0;
        q();
    endtask : bit_io

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send

    // Master acknowledges all but the last byte
    task automatic recv(input logic m_ack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(~m_ack, r);
    endtask : recv
endmodule : otw_master

// file: test/otw_slave_tb.sv
// Testbench: register and temperature traffic through the two-wire slave
module otw_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import otw_pkg::*;

    logic       ref_clk, reset_n, strap, temp_valid, scl_drv, sda_drv, sda_line, scl_line;
    logic       sda_out, sda_oe, scl_out, scl_oe, ack;
    logic [9:0] temp_result;
    logic [15:0] v;
    logic [23:0] exp_r;
    otw_regs_t  regs;
    int         miscompares, num_checks;
    logic [7:0] cmds [3] = '{CMD_DIVIDER, CMD_CONTROL, CMD_TRIM};
    logic [7:0] vals [3] = '{8'hA5, 8'h3C, 8'h81};
    logic [15:0] temps [3] = '{16'h5500, 16'hFF80, 16'hD800};

    // Wired-AND of the open-drain lines
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    assign scl_line = scl_drv & ~(scl_oe & ~scl_out);

    otw_master i_otw_master (.ref_clk(ref_clk), .sda_line(sda_line), .scl_drv(scl_drv),
        .sda_drv(sda_drv));
    otw_slave i_otw_slave (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
        .scl_oe(scl_oe), .address_strap_pin(strap), .temp_result(temp_result),
        .temp_valid(temp_valid), .regs(regs));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Address, command, then n data bytes taken MSB first from d
    task automatic wr_reg(input logic [7:0] cmd, input logic [15:0] d, input int n);
        i_otw_master.start();
        i_otw_master.send({ADDR_UPPER, strap, 1'b0}, ack);
        check("addr ack", ack, 1);
        i_otw_master.send(cmd, ack);
        check("cmd ack", ack, 1);
        for (int i = n - 1; i >= 0; i--) begin
            i_otw_master.send(d[8*i +: 8], ack);
            check("data ack", ack, 1);
        end
        i_otw_master.stop();
    endtask : wr_reg

    // Command written, repeated start, n bytes read, last one refused
    task automatic rd_reg(input logic [7:0] cmd, input int n, output logic [15:0] r);
        logic [7:0] b;
        wr_hdr: begin
            i_otw_master.start();
            i_otw_master.send({ADDR_UPPER, strap, 1'b0}, ack);
            i_otw_master.send(cmd, ack);
        end
        i_otw_master.start();
        i_otw_master.send({ADDR_UPPER, strap, 1'b1}, ack);
        check("read addr ack", ack, 1);
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            i_otw_master.recv(i < n - 1, b);
            r = {r[7:0], b};
        end
        check("released after nack", sda_oe, 0);
        i_otw_master.stop();
    endtask : rd_reg

    initial begin
        reset_n = 1'b0;
        strap = 1'b0;
        temp_valid = 1'b0;
        temp_result = 10'h000;
        miscompares = 0;
        num_checks = 0;
        exp_r = 24'h000000;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("regs reset", regs, exp_r);
        check("clock released", {scl_oe, scl_out}, 24'h000001);
        // Each writable register: reset read, write, field, read back
        for (int i = 0; i < 3; i++) begin
            rd_reg(cmds[i], 1, v);
            check("reset read", v, 16'h0000);
            wr_reg(cmds[i], {8'h00, vals[i]}, 1);
            exp_r[23 - 8*i -: 8] = vals[i];
            check("regs", regs, exp_r);
            rd_reg(cmds[i], 1, v);
            check("read back", v, {8'h00, vals[i]});
        end
        // Second data byte rewrites the same register
        wr_reg(CMD_CONTROL, 16'h1122, 2);
        exp_r[15:8] = 8'h22;
        check("no increment", regs, exp_r);
        // Unknown command: accepted, not stored, reads all ones
        wr_reg(8'h70, 16'h00AA, 1);
        check("unknown write", regs, exp_r);
        rd_reg(8'h70, 1, v);
        check("unknown read", v, 16'h00FF);
        // Foreign address gets no acknowledge
        i_otw_master.start();
        i_otw_master.send({~ADDR_UPPER, strap, 1'b0}, ack);
        check("foreign addr", ack, 0);
        i_otw_master.stop();
        // Strap moves the address; abort mid-byte first
        strap = 1'b1;
        i_otw_master.start();
        i_otw_master.send({ADDR_UPPER, 1'b1, 1'b0}, ack);
        repeat (3) i_otw_master.bit_io(1'b0, ack);
        i_otw_master.stop();
        wr_reg(CMD_TRIM, 16'h005A, 1);
        exp_r[7:0] = 8'h5A;
        check("strap high write", regs, exp_r);
        i_otw_master.start();
        i_otw_master.send({ADDR_UPPER, 1'b0, 1'b0}, ack);
        check("old address", ack, 0);
        i_otw_master.stop();
        // Temperature words, two bytes then one byte
        for (int i = 0; i < 3; i++) begin
            temp_result = temps[i][15:6];
            temp_valid = 1'b1;
            @(negedge ref_clk);
            temp_valid = 1'b0;
            rd_reg(CMD_TEMPERATURE, 2, v);
            check("temp word", v, temps[i]);
            rd_reg(CMD_TEMPERATURE, 1, v);
            check("temp msb", v, {8'h00, temps[i][15:8]});
        end
        tally_and_finish();
    end

    // Watchdog at 50k cycles, about three times the expected run
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
endmodule : otw_slave_tb
